//--- verilog/ssq_consts.vh
`ifndef SSQ_CONSTS_VH
`define SSQ_CONSTS_VH
// ==========================================================
// Register offsets (8-bit address, word per register)
`define SSQ_ADDR_MODE      8'h00
`define SSQ_ADDR_LINES     8'h01
`define SSQ_ADDR_POLES     8'h02
`define SSQ_ADDR_OFFSET    8'h03
`define SSQ_ADDR_SETUP     8'h04
`define SSQ_ADDR_SETSTAT   8'h05
`define SSQ_ADDR_COUNT     8'h06
`define SSQ_ADDR_SPEED     8'h07
`define SSQ_ADDR_ANGLE     8'h08
`define SSQ_ADDR_IRQSTAT   8'h09
`define SSQ_ADDR_IRQMASK   8'h0A
`define SSQ_ADDR_CONTROL   8'h0B
// ==========================================================
// Operation mode codes
`define SSQ_MODE_OFF       16'h0000
`define SSQ_MODE_QUAD      16'h0004
`define SSQ_MODE_QUAD_INV  16'h0068
`define SSQ_MODE_QREF      16'h03EC
`define SSQ_MODE_QREF_INV  16'h0450
`define SSQ_MODE_RES       16'h2710
`define SSQ_MODE_RES_INV   16'h2774
// ==========================================================
// Settings limits and reset values
`define SSQ_LINES_MIN      14'h0001
`define SSQ_LINES_MAX      14'h2000
`define SSQ_LINES_RESET    14'h0400
`define SSQ_POLES_MIN      3'h1
`define SSQ_POLES_MAX      3'h7
`define SSQ_POLES_RESET    3'h1
`define SSQ_SETUP_OFFSET   16'h0226
// Offset: signed, 65536 units per electrical turn, range +-1 turn
`define SSQ_OFFSET_MAX     18'h1_0000
// Setup status codes
`define SSQ_SST_IDLE       3'h0
`define SSQ_SST_STO        3'h1
`define SSQ_SST_RUN        3'h2
`define SSQ_SST_DONE       3'h3
`define SSQ_SST_FAULT      3'h4
// Interrupt status bits
`define SSQ_IRQ_REFERR     0
`define SSQ_IRQ_DIRFAULT   1
`define SSQ_IRQ_SETDONE    2
`define SSQ_IRQ_REFPULSE   3
// Timing
`define SSQ_CLK_HZ         40000000
`define SSQ_SPEED_WIN_US   2000
`define SSQ_SPEED_WIN_CYC  ((`SSQ_CLK_HZ / 1000000) * `SSQ_SPEED_WIN_US)
`define SSQ_TUNE_STEPS     16'h0100
`endif

//--- verilog/ssq_sensor2.v
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// R1 - Mode zero: no speed measurement
// R2 - Mode 4: quadrature, direction, four edges
// R3 - Mode 104: as 4, speed sign inverted
// R4 - Mode 1004: quadrature plus reference pulse check
// R5 - Mode 1104: reference mode, inverted speed
// R6 - Mode 10000: resolver angle and speed
// R7 - Mode 10100: resolver, inverted speed
// R8 - Line count 1..8192, default 1024
// R9 - Tracks count edges up to 300 kHz
// R10 - Four-edge counting is fixed
// R11 - Pole pairs 1..7, default 1
// R12 - Angle wraps once per pole pair; code ignores poles and wraps once per resolver turn
// R13 - Setup code 550 starts offset tuning
// R14 - Tuning reports safe-torque-off release request
// R15 - Valid offset stored, then device reset
// R16 - Direction disagreement raises mismatch fault
// R17 - Clockwise rotation gives positive speed
// R18 - Double track change is error, uncounted
// R19 - Offset added to electrical angle
`include "ssq_consts.vh"
module ssq_sensor2 (
    input  wire        i_clk,             // 40 MHz system clock
    input  wire        i_reset,           // Synchronous reset, active high
    input  wire [7:0]  i_addr,            // Register address
    input  wire [31:0] i_wdata,           // Register write data
    input  wire        i_wr,              // Write strobe
    input  wire        i_rd,              // Read strobe
    output reg  [31:0] o_rdata,           // Read data, cycle after strobe
    output wire        o_irq,             // Level interrupt
    input  wire        i_track_a,         // Encoder track A
    input  wire        i_track_b,         // Encoder track B
    input  wire        i_track_ref,       // Encoder reference pulse
    input  wire [15:0] i_res_angle,       // Resolver angle from sin/cos converter
    input  wire        i_safe_torque_off_inputs, // Safe-torque-off release state
    input  wire        i_motor_dir,       // Motor commanded direction, 1 = clockwise
    input  wire        i_motor_running,   // Motor turning under drive control
    output reg  [15:0] o_elec_angle,      // Offset electrical angle for commutation
    output reg  [31:0] o_speed,           // Signed speed, counts per window
    output reg         o_meas_active,     // Measurement enabled
    output reg         o_direction_mismatch_fault, // Direction fault level
    output reg         o_device_reset     // One-cycle request to reset device
);
    // ==========================================================
    // Settings registers
    reg [15:0] mode;            // Operation mode
    reg [13:0] lines;           // Division marks
    reg [2:0]  poles;           // Resolver pole pairs
    reg [17:0] offset;          // Signed angle offset
    reg [15:0] setup_sel;       // Setup selection
    reg [2:0]  setup_stat;      // Setup status
    reg [3:0]  irq_stat;        // Sticky events
    reg [3:0]  irq_mask;        // Interrupt mask
    reg [31:0] position;        // Signed edge counter
    reg [31:0] win_count;       // Edges in current window
    reg [31:0] win_timer;       // Window timer
    reg [1:0]  ab_prev;         // Previous track state
    reg        ref_prev;        // Previous reference level
    reg [15:0] edges_since_ref; // Edges since last reference pulse
    reg [15:0] ang_prev;        // Previous resolver angle
    // ==========================================================
    // Mode decode
    wire quad_mode = (mode == `SSQ_MODE_QUAD) || (mode == `SSQ_MODE_QUAD_INV) ||
                     (mode == `SSQ_MODE_QREF) || (mode == `SSQ_MODE_QREF_INV); // see R2 see R10
    wire ref_mode  = (mode == `SSQ_MODE_QREF) || (mode == `SSQ_MODE_QREF_INV);  // see R4
    wire res_mode  = (mode == `SSQ_MODE_RES) || (mode == `SSQ_MODE_RES_INV);    // see R6
    wire inv_mode  = (mode == `SSQ_MODE_QUAD_INV) || (mode == `SSQ_MODE_QREF_INV) ||
                     (mode == `SSQ_MODE_RES_INV); // see R3 see R5 see R7
    wire active    = quad_mode || res_mode;       // see R1
    // ==========================================================
    // Quadrature decode, sampled every 25 ns so 300 kHz is ample
    wire [1:0] ab_now  = {i_track_a, i_track_b};  // see R9
    wire       ab_chg  = (ab_now != ab_prev);
    wire       ab_both = (ab_now[0] != ab_prev[0]) && (ab_now[1] != ab_prev[1]);
    // Forward when A leads B: clockwise counts up
    wire       ab_fwd  = (ab_prev[0] ^ ab_now[1]);  // see R17
    reg  signed [1:0] quad_step;
    always @* begin
        quad_step = 2'sb00;
        if (quad_mode && ab_chg && !ab_both) begin    // see R18
            quad_step = ab_fwd ? 2'sb01 : 2'sb11;     // see R2
        end
    end
    wire quad_err = quad_mode && ab_both;             // see R18
    // Reference check: edges between pulses must equal 4 * lines
    wire [15:0] lines4   = {lines, 2'b00};            // see R10 see R8
    wire        ref_rise = i_track_ref && !ref_prev;
    wire        ref_err  = ref_mode && ref_rise && (edges_since_ref != lines4) &&
                           (edges_since_ref != 16'h0000); // see R4
    // ==========================================================
    // Resolver step, wrap-aware difference
    wire [15:0] ang_diff = i_res_angle - ang_prev;    // see R6 see R12
    wire [15:0] ang_sum  = i_res_angle + offset[15:0]; // see R19
    wire [31:0] res_step = {{16{ang_diff[15]}}, ang_diff};
    wire [31:0] step32   = res_mode ? res_step : {{30{quad_step[1]}}, quad_step};
    // ==========================================================
    // Measurement datapath
    always @(posedge i_clk) begin
        if (i_reset) begin
            ab_prev         <= ab_now;
            ref_prev        <= 1'b0;
            edges_since_ref <= 16'h0000;
            ang_prev        <= i_res_angle;
            position        <= 32'h0000_0000;
            win_count       <= 32'h0000_0000;
            win_timer       <= 32'h0000_0000;
            o_speed         <= 32'h0000_0000;
            o_elec_angle    <= 16'h0000;
            o_meas_active   <= 1'b0;
        end else begin
            ab_prev       <= ab_now;
            ref_prev      <= i_track_ref;
            ang_prev      <= i_res_angle;
            o_meas_active <= active;
            if (!active) begin
                // Off: no counting, speed held at zero
                win_count <= 32'h0000_0000;                    // see R1
                win_timer <= 32'h0000_0000;
                o_speed   <= 32'h0000_0000;
            end else begin
                position  <= position + step32;
                if (win_timer == `SSQ_SPEED_WIN_CYC - 1) begin
                    win_timer <= 32'h0000_0000;
                    win_count <= 32'h0000_0000;
                    // Sign inversion equals swapping tracks
                    o_speed   <= inv_mode ? (32'h0000_0000 - (win_count + step32))
                                          : (win_count + step32); // see R3 see R7
                end else begin
                    win_timer <= win_timer + 32'h0000_0001;
                    win_count <= win_count + step32;
                end
            end
            // Reference pulse edge tally
            if (ref_rise) begin
                edges_since_ref <= 16'h0000;
            end else if (quad_step != 2'sb00) begin
                edges_since_ref <= edges_since_ref + 16'h0001;
            end
            // Electrical angle is resolver angle plus offset; poles is not applied
            if (res_mode) begin
                o_elec_angle <= ang_sum;                       // see R12 see R19
            end else begin
                o_elec_angle <= 16'h0000;
            end
        end
    end
    // ==========================================================
    // Auto-tuning sequence
    localparam ST_IDLE = 3'd0;
    localparam ST_STO  = 3'd1;
    localparam ST_RUN  = 3'd2;
    localparam ST_DONE = 3'd3;
    localparam ST_FLT  = 3'd4;
    reg [2:0]  tstate;      // Tuning state
    reg [15:0] tsteps;      // Samples taken
    reg [15:0] tune_angle;  // Captured offset candidate
    wire tune_start = i_wr && (i_addr == `SSQ_ADDR_SETUP) &&
                      (i_wdata[15:0] == `SSQ_SETUP_OFFSET);   // see R13
    // Resolver direction versus motor direction while turning
    wire res_fwd   = !ang_diff[15] && (ang_diff != 16'h0000);
    wire res_back  = ang_diff[15];
    wire dir_bad   = i_motor_running && ((i_motor_dir && res_back) || (!i_motor_dir && res_fwd));
    reg  fault_ev;   // One-cycle fault event
    reg  done_ev;    // One-cycle completion event
    always @(posedge i_clk) begin
        if (i_reset) begin
            tstate         <= ST_IDLE;
            tsteps         <= 16'h0000;
            tune_angle     <= 16'h0000;
            setup_stat     <= `SSQ_SST_IDLE;
            o_device_reset <= 1'b0;
            o_direction_mismatch_fault <= 1'b0;
            fault_ev       <= 1'b0;
            done_ev        <= 1'b0;
        end else begin
            o_device_reset <= 1'b0;
            fault_ev       <= 1'b0;
            done_ev        <= 1'b0;
            case (tstate)
                ST_IDLE: begin
                    if (tune_start) begin
                        tstate     <= ST_STO;
                        setup_stat <= `SSQ_SST_STO;            // see R14
                        o_direction_mismatch_fault <= 1'b0;
                    end
                end
                ST_STO: begin
                    // Wait for operator to release safe-torque-off
                    if (i_safe_torque_off_inputs) begin       // see R14
                        tstate     <= ST_RUN;
                        tsteps     <= 16'h0000;
                        setup_stat <= `SSQ_SST_RUN;
                    end
                end
                ST_RUN: begin
                    if (dir_bad) begin
                        tstate     <= ST_FLT;
                        setup_stat <= `SSQ_SST_FAULT;
                        o_direction_mismatch_fault <= 1'b1;    // see R16
                        fault_ev   <= 1'b1;
                    end else if (i_motor_running) begin
                        tsteps <= tsteps + 16'h0001;
                        if (tsteps == `SSQ_TUNE_STEPS - 16'h0001) begin
                            tune_angle <= 16'h0000 - i_res_angle; // see R15
                            tstate     <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    // Offset stored and device reset pulse raised on the same edge
                    setup_stat     <= `SSQ_SST_DONE;
                    o_device_reset <= 1'b1;                    // see R15
                    done_ev        <= 1'b1;
                    tstate         <= ST_IDLE;
                end
                ST_FLT: begin
                    if (tune_start) begin
                        tstate     <= ST_STO;
                        setup_stat <= `SSQ_SST_STO;
                        o_direction_mismatch_fault <= 1'b0;
                    end
                end
                default: begin
                    tstate <= ST_IDLE;
                end
            endcase
        end
    end
    // ==========================================================
    // Register writes and sticky interrupt status
    wire [3:0] irq_ev;
    assign irq_ev[`SSQ_IRQ_REFERR]   = ref_err || quad_err;     // see R18
    assign irq_ev[`SSQ_IRQ_DIRFAULT] = fault_ev;
    assign irq_ev[`SSQ_IRQ_SETDONE]  = done_ev;
    assign irq_ev[`SSQ_IRQ_REFPULSE] = ref_mode && ref_rise;
    wire [13:0] wr_lines = i_wdata[13:0];
    wire [2:0]  wr_poles = i_wdata[2:0];
    wire [17:0] wr_off   = i_wdata[17:0];
    wire [17:0] wr_abs   = wr_off[17] ? (18'h0_0000 - wr_off) : wr_off;
    always @(posedge i_clk) begin
        if (i_reset) begin
            mode      <= `SSQ_MODE_OFF;
            lines     <= `SSQ_LINES_RESET;
            poles     <= `SSQ_POLES_RESET;
            offset    <= 18'h0_0000;
            setup_sel <= 16'h0000;
            irq_mask  <= 4'h0;
            irq_stat  <= 4'h0;
        end else begin
            if (i_wr) begin
                case (i_addr)
                    `SSQ_ADDR_MODE: begin
                        // Unknown codes are ignored
                        if (i_wdata[15:0] == `SSQ_MODE_OFF || i_wdata[15:0] == `SSQ_MODE_QUAD ||
                            i_wdata[15:0] == `SSQ_MODE_QUAD_INV || i_wdata[15:0] == `SSQ_MODE_QREF ||
                            i_wdata[15:0] == `SSQ_MODE_QREF_INV || i_wdata[15:0] == `SSQ_MODE_RES ||
                            i_wdata[15:0] == `SSQ_MODE_RES_INV) begin
                            mode <= i_wdata[15:0];
                        end
                    end
                    `SSQ_ADDR_LINES: begin
                        if (wr_lines >= `SSQ_LINES_MIN && wr_lines <= `SSQ_LINES_MAX) begin
                            lines <= wr_lines;                 // see R8
                        end
                    end
                    `SSQ_ADDR_POLES: begin
                        if (wr_poles >= `SSQ_POLES_MIN) begin
                            poles <= wr_poles;                 // see R11
                        end
                    end
                    `SSQ_ADDR_OFFSET: begin
                        if (wr_abs <= `SSQ_OFFSET_MAX) begin
                            offset <= wr_off;                  // see R19
                        end
                    end
                    `SSQ_ADDR_SETUP: begin
                        setup_sel <= i_wdata[15:0];
                    end
                    `SSQ_ADDR_IRQMASK: begin
                        irq_mask <= i_wdata[3:0];
                    end
                    default: begin
                    end
                endcase
            end
            if (tstate == ST_DONE) begin
                offset <= {{2{tune_angle[15]}}, tune_angle};   // see R15
            end
            // Read clears, but a new event wins
            if (i_rd && i_addr == `SSQ_ADDR_IRQSTAT) begin
                irq_stat <= irq_ev;
            end else begin
                irq_stat <= irq_stat | irq_ev;
            end
        end
    end
    assign o_irq = |(irq_stat & irq_mask);
    // ==========================================================
    // Read data, one cycle after the strobe
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                `SSQ_ADDR_MODE:    o_rdata <= {16'h0000, mode};
                `SSQ_ADDR_LINES:   o_rdata <= {18'h0_0000, lines};
                `SSQ_ADDR_POLES:   o_rdata <= {29'h0000_0000, poles};
                `SSQ_ADDR_OFFSET:  o_rdata <= {{14{offset[17]}}, offset};
                `SSQ_ADDR_SETUP:   o_rdata <= {16'h0000, setup_sel};
                `SSQ_ADDR_SETSTAT: o_rdata <= {29'h0000_0000, setup_stat};
                `SSQ_ADDR_COUNT:   o_rdata <= position;
                `SSQ_ADDR_SPEED:   o_rdata <= o_speed;
                `SSQ_ADDR_ANGLE:   o_rdata <= {16'h0000, o_elec_angle};
                `SSQ_ADDR_IRQSTAT: o_rdata <= {28'h000_0000, irq_stat};
                `SSQ_ADDR_IRQMASK: o_rdata <= {28'h000_0000, irq_mask};
                default:           o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end
endmodule

//--- sim/ssq_sensor2_chk.sv
`timescale 1ns/1ps
`include "ssq_consts.vh"
module ssq_sensor2_chk (
    input wire        i_clk,
    input wire        i_reset,
    input wire [7:0]  i_addr,
    input wire [31:0] i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire [31:0] o_rdata,
    input wire        i_safe_torque_off_inputs,
    input wire        i_motor_running,
    input wire [15:0] o_elec_angle,
    input wire [31:0] o_speed,
    input wire        o_meas_active,
    input wire        o_direction_mismatch_fault,
    input wire        o_device_reset
);
    // ==========================================================
    // Released running cycles since the setup register was last written
    reg [15:0] tune_cnt;
    always @(posedge i_clk) begin
        if (i_reset || (i_wr && i_addr == `SSQ_ADDR_SETUP)) begin
            tune_cnt <= 16'h0000;
        end else if (i_safe_torque_off_inputs && i_motor_running && tune_cnt != 16'hFFFF) begin
            tune_cnt <= tune_cnt + 16'h0001;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    AST_ANGLE_OFF: assert property ((!o_meas_active)[*3] |-> o_elec_angle == 16'h0000)
        else $error("angle driven while measurement is off");
    AST_MODE_OFF: assert property (i_wr && i_addr == `SSQ_ADDR_MODE && i_wdata == 32'h0000_0000
        |-> ##[1:2] !o_meas_active) else $error("measurement still active after mode off");
    AST_MODE_QUAD: assert property (i_wr && i_addr == `SSQ_ADDR_MODE && i_wdata == 32'h0000_0004
        |-> ##[1:2] o_meas_active) else $error("quadrature mode did not start measurement");
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    AST_RESET_CLEAR: assert property ($fell(i_reset) |-> o_speed == 32'h0000_0000 && !o_device_reset)
        else $error("outputs not cleared by reset");
    AST_RST_PULSE: assert property (o_device_reset |=> !o_device_reset)
        else $error("device reset request longer than one cycle");
    AST_RST_AFTER_TUNE: assert property (o_device_reset |-> tune_cnt >= 16'h00FF)
        else $error("device reset without a completed tuning run");
    AST_FAULT_EXCL: assert property (o_direction_mismatch_fault |-> !o_device_reset)
        else $error("offset stored while direction fault stands");
endmodule
bind ssq_sensor2 ssq_sensor2_chk u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_safe_torque_off_inputs(i_safe_torque_off_inputs),
    .i_motor_running(i_motor_running), .o_elec_angle(o_elec_angle), .o_speed(o_speed),
    .o_meas_active(o_meas_active), .o_direction_mismatch_fault(o_direction_mismatch_fault),
    .o_device_reset(o_device_reset));

//--- sim/ssq_enc_model.sv
`timescale 1ns/1ps
module ssq_enc_model #(
    parameter LINES = 2              // Encoder lines per turn
) (
    input  wire        i_clk,        // Bench clock
    input  wire        i_step,       // One shaft step per pulse
    input  wire        i_cw,         // Step direction, 1 = clockwise
    input  wire        i_glitch,     // Flip both tracks at once
    output wire        o_track_a,    // Track A
    output wire        o_track_b,    // Track B
    output wire        o_track_ref,  // Reference pulse
    output reg  [15:0] o_res_angle   // Resolver angle
);
    // ==========================================================
    // Shaft position in edges; clockwise lets A lead B
    reg [31:0] pos = 32'h0000_0001;
    initial o_res_angle = 16'hF000;
    always @(posedge i_clk) begin
        if (i_glitch) begin
            pos <= pos + 32'h0000_0002;  // Illegal double change
        end else if (i_step) begin
            pos         <= i_cw ? pos + 32'h0000_0001 : pos - 32'h0000_0001;
            o_res_angle <= i_cw ? o_res_angle + 16'h0100 : o_res_angle - 16'h0100;
        end
    end
    assign o_track_a   = pos[1] ^ pos[0];
    assign o_track_b   = pos[1];
    assign o_track_ref = (pos % (4 * LINES)) == 0;  // Once per turn
endmodule

//--- sim/test_speed_sensor2_quad_resolver_eval.sv
`timescale 1ns/1ps
`include "ssq_consts.vh"
module test_speed_sensor2_quad_resolver_eval;
    // ==========================================================
    // Stimulus and observed signals
    reg         i_clk = 1'b0;
    reg         i_reset = 1'b1;
    reg  [7:0]  i_addr = 8'h00;
    reg  [31:0] i_wdata = 32'h0000_0000;
    reg         i_wr = 1'b0;
    reg         i_rd = 1'b0;
    reg         i_safe_torque_off_inputs = 1'b0;
    reg         i_motor_dir = 1'b1;
    reg         i_motor_running = 1'b0;
    reg         step = 1'b0, cw = 1'b1, glitch = 1'b0;  // Encoder model controls
    wire        track_a, track_b, track_ref, o_irq, o_meas_active, o_fault, o_dev_rst;
    wire [15:0] res_angle, o_elec_angle;
    wire [31:0] o_rdata, o_speed;
    reg  [31:0] rdv, p0;                                // Read value, saved position
    integer     fails = 0, checked = 0, cycles = 0, k;
    localparam [111:0] CODES = {`SSQ_MODE_OFF, `SSQ_MODE_QUAD, `SSQ_MODE_QUAD_INV, `SSQ_MODE_QREF,
                                `SSQ_MODE_QREF_INV, `SSQ_MODE_RES, `SSQ_MODE_RES_INV};
    always #12.5 i_clk = ~i_clk;
    ssq_enc_model #(.LINES(2)) u_enc (.i_clk(i_clk), .i_step(step), .i_cw(cw), .i_glitch(glitch),
        .o_track_a(track_a), .o_track_b(track_b), .o_track_ref(track_ref), .o_res_angle(res_angle));
    ssq_sensor2 u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_track_a(track_a), .i_track_b(track_b),
        .i_track_ref(track_ref), .i_res_angle(res_angle), .i_safe_torque_off_inputs(i_safe_torque_off_inputs),
        .i_motor_dir(i_motor_dir), .i_motor_running(i_motor_running), .o_elec_angle(o_elec_angle),
        .o_speed(o_speed), .o_meas_active(o_meas_active), .o_direction_mismatch_fault(o_fault),
        .o_device_reset(o_dev_rst));
    // ==========================================================
    // Bus cycles and comparisons
    task wr(input [7:0] a, input [31:0] d); begin
        @(posedge i_clk); i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk); i_wr <= 1'b0;
    end endtask
    task rd(input [7:0] a); begin
        @(posedge i_clk); i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk); i_rd <= 1'b0;
        #1 rdv = o_rdata;  // Data stand only in this cycle
    end endtask
    task cmp(input [31:0] got, input [31:0] exp); begin
        checked = checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    end endtask
    task cmpb(input got, input exp); begin
        cmp({31'h0000_0000, got}, {31'h0000_0000, exp});
    end endtask
    task rdcmp(input [7:0] a, input [31:0] exp); begin
        rd(a); cmp(rdv, exp);
    end endtask
    // Shaft steps with a gap of idle cycles after each
    task steps(input dir, input integer n, input integer gap); begin
        repeat (n) begin
            @(posedge i_clk); cw <= dir; step <= 1'b1;
            @(posedge i_clk); step <= 1'b0;
            repeat (gap) @(posedge i_clk);
        end
    end endtask
    task end_of_test; begin
        if (fails == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    end endtask
    // ==========================================================
    // Scenarios
    task t_defaults; begin
        rdcmp(`SSQ_ADDR_LINES, 32'h0000_0400);
        rdcmp(`SSQ_ADDR_POLES, 32'h0000_0001);
        cmpb(o_meas_active, 1'b0);
    end endtask
    task t_speed_inverted; begin
        wr(`SSQ_ADDR_MODE, 32'h0000_0068);
        for (k = 0; k < 640 && o_speed === 32'h0000_0000; k = k + 1) steps(1'b1, 1, 134);
        cmpb(o_speed[31], 1'b1);
    end endtask
    task t_limits; begin
        wr(`SSQ_ADDR_LINES, 32'h0000_2001); rdcmp(`SSQ_ADDR_LINES, 32'h0000_0400);
        wr(`SSQ_ADDR_LINES, 32'h0000_2000); rdcmp(`SSQ_ADDR_LINES, 32'h0000_2000);
        wr(`SSQ_ADDR_LINES, 32'h0000_0000); rdcmp(`SSQ_ADDR_LINES, 32'h0000_2000);
        wr(`SSQ_ADDR_POLES, 32'h0000_0007); rdcmp(`SSQ_ADDR_POLES, 32'h0000_0007);
        wr(`SSQ_ADDR_POLES, 32'h0000_0000); rdcmp(`SSQ_ADDR_POLES, 32'h0000_0007);
        wr(`SSQ_ADDR_LINES, 32'h0000_0002);
        for (k = 0; k < 7; k = k + 1) begin
            wr(`SSQ_ADDR_MODE, {16'h0000, CODES[k*16 +: 16]});
            rdcmp(`SSQ_ADDR_MODE, {16'h0000, CODES[k*16 +: 16]});
            cmpb(o_meas_active, CODES[k*16 +: 16] != 16'h0000);
        end
        wr(`SSQ_ADDR_MODE, 32'h0000_0005); rdcmp(`SSQ_ADDR_MODE, 32'h0000_0000);
    end endtask
    task t_quadrature; begin
        wr(`SSQ_ADDR_MODE, 32'h0000_0004); rd(`SSQ_ADDR_COUNT); p0 = rdv;
        steps(1'b1, 8, 134); rdcmp(`SSQ_ADDR_COUNT, p0 + 32'h0000_0008);
        steps(1'b0, 3, 134); rdcmp(`SSQ_ADDR_COUNT, p0 + 32'h0000_0005);
        wr(`SSQ_ADDR_IRQMASK, 32'h0000_0000); rd(`SSQ_ADDR_IRQSTAT);
        @(posedge i_clk); glitch <= 1'b1;
        @(posedge i_clk); glitch <= 1'b0;
        repeat (8) @(posedge i_clk);
        cmpb(o_irq, 1'b0);
        rdcmp(`SSQ_ADDR_COUNT, p0 + 32'h0000_0005);
        wr(`SSQ_ADDR_IRQMASK, 32'h0000_0001); #1 cmpb(o_irq, 1'b1);
        rd(`SSQ_ADDR_IRQSTAT); cmp(rdv & 32'h0000_0001, 32'h0000_0001);
        cmpb(o_irq, 1'b0);
    end endtask
    task t_reference; begin
        wr(`SSQ_ADDR_MODE, 32'h0000_03EC); rd(`SSQ_ADDR_IRQSTAT);
        steps(1'b1, 16, 134); rd(`SSQ_ADDR_IRQSTAT); cmpb(rdv[3], 1'b1);
    end endtask
    task t_resolver; begin
        wr(`SSQ_ADDR_MODE, 32'h0000_2710); wr(`SSQ_ADDR_OFFSET, 32'h0000_4000);
        repeat (3) @(posedge i_clk);
        cmp({16'h0000, o_elec_angle}, {16'h0000, res_angle + 16'h4000});
        wr(`SSQ_ADDR_OFFSET, 32'hFFFF_F000); wr(`SSQ_ADDR_OFFSET, 32'h0001_0001);
        repeat (3) @(posedge i_clk);
        cmp({16'h0000, o_elec_angle}, {16'h0000, res_angle - 16'h1000});
    end endtask
    task t_tuning; begin
        wr(`SSQ_ADDR_SETUP, 32'h0000_0226);
        rdcmp(`SSQ_ADDR_SETSTAT, {29'h0000_0000, `SSQ_SST_STO});
        i_safe_torque_off_inputs <= 1'b1; i_motor_running <= 1'b1;
        steps(1'b1, 20, 4);
        for (k = 0; k < 600 && o_dev_rst !== 1'b1; k = k + 1) @(negedge i_clk);
        cmpb(o_dev_rst, 1'b1);
        rdcmp(`SSQ_ADDR_SETSTAT, {29'h0000_0000, `SSQ_SST_DONE});
        rd(`SSQ_ADDR_OFFSET); cmp(rdv[15:0], {16'h0000, -res_angle});
        wr(`SSQ_ADDR_SETUP, 32'h0000_0226); steps(1'b0, 40, 4);
        cmpb(o_fault, 1'b1);
        rdcmp(`SSQ_ADDR_SETSTAT, {29'h0000_0000, `SSQ_SST_FAULT});
        i_safe_torque_off_inputs <= 1'b0; i_motor_running <= 1'b0;
    end endtask
    // ==========================================================
    // Main sequence and hang guard
    initial begin
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        t_defaults; t_speed_inverted; t_limits; t_quadrature; t_reference; t_resolver; t_tuning;
        end_of_test;
    end
    always @(posedge i_clk) begin
        cycles = cycles + 1;
        if (cycles == 98000) begin
            fails = fails + 1;
            end_of_test;
        end
    end
endmodule
